// *** logic/apd_pkg.sv ***
// constants for the analog output parameter and diagnostic record block
`default_nettype none
package apd_pkg;
    // ---------------------------------------------------------------
    // record numbers and object indices
    // ---------------------------------------------------------------
    localparam logic [7:0]  REC_DIAG_HEAD  = 8'h00;   // first four diag bytes, also param record
    localparam logic [7:0]  REC_DIAG_FULL  = 8'h01;
    localparam logic [7:0]  REC_FUNC_BASE  = 8'h80;   // channel 0 function number
    localparam logic [15:0] IDX_DIAG_HEAD  = 16'h2f00;
    localparam logic [15:0] IDX_DIAG_FULL  = 16'h2f01;
    localparam logic [15:0] IDX_DIAG_ALT   = 16'h5005;
    localparam logic [4:0]  BYTE_SHORT_DET = 5'h01;   // byte of the param record
    localparam logic [4:0]  HEAD_BYTES     = 5'h04;
    localparam logic [4:0]  DIAG_BYTES     = 5'h14;
    // ---------------------------------------------------------------
    // byte positions inside the diagnostic record
    // ---------------------------------------------------------------
    localparam logic [4:0]  POS_MOD_FLAGS  = 5'h00;
    localparam logic [4:0]  POS_CLASS      = 5'h01;
    localparam logic [4:0]  POS_INT_FLAGS  = 5'h03;
    localparam logic [4:0]  POS_KIND       = 5'h04;
    localparam logic [4:0]  POS_BITS       = 5'h05;
    localparam logic [4:0]  POS_COUNT      = 5'h06;
    localparam logic [4:0]  POS_SUMMARY    = 5'h07;
    localparam logic [4:0]  POS_CH_ERR     = 5'h08;
    localparam logic [4:0]  POS_STAMP      = 5'h10;
    // ---------------------------------------------------------------
    // fixed identity bytes and reset values
    // ---------------------------------------------------------------
    localparam logic [7:0]  MODULE_CLASS   = 8'h15;   // analog class, channel info present
    localparam logic [7:0]  CHANNEL_KIND   = 8'h73;   // analog output
    localparam logic [7:0]  BITS_PER_CH    = 8'h08;
    localparam logic [7:0]  CH_COUNT       = 8'h04;
    localparam logic [7:0]  SHORT_DET_RST  = 8'h00;
    localparam logic [7:0]  FUNC_RST       = 8'h10;
    // ---------------------------------------------------------------
    // function numbers and scaling
    // ---------------------------------------------------------------
    localparam logic [7:0]  FN_STD         = 8'h10;   // nominal 27648 scaling
    localparam logic [7:0]  FN_ALT         = 8'h20;   // nominal 16384 scaling
    localparam logic [7:0]  FN_OFF         = 8'hff;
    localparam logic [15:0] STD_MAX        = 16'h7eff;  // 32511 overrange top
    localparam logic [15:0] ALT_MAX        = 16'h5000;  // 20480 overrange top
    // dac full scale is 12.5 V; gain = 4095*10/12.5/nominal*65536
    localparam logic [13:0] STD_GAIN       = 14'h1e55;  // 7765 for 27648 = 10 V
    localparam logic [13:0] ALT_GAIN       = 14'h3330;  // 13104 for 16384 = 10 V
    // ---------------------------------------------------------------
    // bit positions of the flag bytes
    // ---------------------------------------------------------------
    localparam int MF_FAIL = 0, MF_INT = 1, MF_EXT = 2, MF_CHAN = 3, MF_AUX = 4, MF_PARAM = 7;
    localparam int IF_OVF = 3, IF_COMM = 4;
    localparam int CE_PARAM = 0, CE_SHORT = 3;
    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int TICK_NS  = 1000;
    localparam int CLK_NS   = 40;
    localparam int TICK_CYC = TICK_NS / CLK_NS;
endpackage
`default_nettype wire

// *** logic/apd_record.sv ***
// parameter and diagnostic record logic of a four channel analog output module
`timescale 1ns/1ps
`default_nettype none
module apd_record #(
    parameter int NCH = 4,                      // channel count
    parameter int DW  = 12                      // dac code width
) (
    input  wire logic            clk_sys,       // system clock
    input  wire logic            rstn,          // async reset, active low
    input  wire logic            rec_wr,        // record byte write strobe
    input  wire logic            rec_rd,        // record byte read strobe
    input  wire logic            use_index,     // address by object index
    input  wire logic [7:0]      rec_num,       // record set number
    input  wire logic [15:0]     obj_index,     // object index
    input  wire logic [4:0]      rec_byte,      // byte within record
    input  wire logic [7:0]      rec_wdata,     // write byte
    output logic      [7:0]      rec_rdata,     // read byte
    output logic                 rec_ack,       // access answered
    output logic                 rec_err,       // access refused
    input  wire logic [NCH*16-1:0] ao_value,    // signed digital values
    input  wire logic [NCH-1:0]  short_pin,     // short detected per channel
    input  wire logic [5:0]      fault_pin,     // fail,int,ext,aux,ovf,comm
    output logic [NCH*DW-1:0]    dac_code,      // scaled output codes
    output logic [NCH-1:0]       chan_on,       // channel active
    output logic [NCH-1:0]       chan_err_led   // channel error indicator
);
    localparam int NIN = NCH + 6;

    // ---------------------------------------------------------------
    // reset release and input synchronisers
    // ---------------------------------------------------------------
    logic [1:0]     rst_sync_r;
    logic           rst_n;
    logic [NIN-1:0] s1_r, s2_r, s3_r, in_r;

    // two-stage reset release
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) rst_sync_r <= 2'b00;
        else       rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
    assign rst_n = rst_sync_r[1];

    // three stages; level accepted when last two agree
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            in_r <= '0;
        end else begin
            s1_r <= {fault_pin, short_pin};
            s2_r <= s1_r;
            s3_r <= s2_r;
            for (int i = 0; i < NIN; i++) begin
                if (s2_r[i] == s3_r[i]) in_r[i] <= s3_r[i];
            end
        end
    end

    // ---------------------------------------------------------------
    // microsecond ticker
    // ---------------------------------------------------------------
    logic [4:0]  pre_r;
    logic [31:0] us_r;
    logic        tick;
    assign tick = (pre_r == 5'(apd_pkg::TICK_CYC - 1));

    // prescaler and free running counter, wraps by overflow
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pre_r <= 5'h0_0;
            us_r  <= 32'h0000_0000;
        end else begin
            pre_r <= tick ? 5'h0_0 : pre_r + 5'h0_1;
            if (tick) us_r <= us_r + 32'h0000_0001;
        end
    end

    // ---------------------------------------------------------------
    // parameter storage
    // ---------------------------------------------------------------
    logic [3:0]       short_det_r;
    logic [7:0]       func_r [NCH];
    logic [7:0]       rnum;
    logic             is_func, is_head, is_full;
    assign rnum    = rec_num - apd_pkg::REC_FUNC_BASE;
    assign is_func = !use_index && rec_num >= apd_pkg::REC_FUNC_BASE && rnum < 8'(NCH);
    assign is_head = use_index ? obj_index == apd_pkg::IDX_DIAG_HEAD : rec_num == apd_pkg::REC_DIAG_HEAD;
    assign is_full = use_index ? (obj_index == apd_pkg::IDX_DIAG_FULL || obj_index == apd_pkg::IDX_DIAG_ALT)
                               : rec_num == apd_pkg::REC_DIAG_FULL;

    // parameter writes by record number
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            short_det_r <= apd_pkg::SHORT_DET_RST[3:0];
            for (int i = 0; i < NCH; i++) func_r[i] <= apd_pkg::FUNC_RST;
        end else if (rec_wr && !use_index) begin
            if (rec_num == apd_pkg::REC_DIAG_HEAD && rec_byte == apd_pkg::BYTE_SHORT_DET)
                short_det_r <= rec_wdata[3:0];
            if (is_func && rec_byte == 5'h0_0)
                func_r[rnum[1:0]] <= rec_wdata;
        end
    end

    // ---------------------------------------------------------------
    // diagnostic flags
    // ---------------------------------------------------------------
    logic [7:0]     ch_err [NCH];
    logic [NCH-1:0] summary, par_err;
    logic [7:0]     mod_flags, int_flags;
    logic [31:0]    flags_all, flags_prev_r, stamp_r;

    // per-channel error bytes and summary
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            par_err[i] = !(func_r[i] == apd_pkg::FN_STD || func_r[i] == apd_pkg::FN_ALT
                           || func_r[i] == apd_pkg::FN_OFF);
            ch_err[i] = 8'h00;
            ch_err[i][apd_pkg::CE_PARAM] = par_err[i];
            ch_err[i][apd_pkg::CE_SHORT] = in_r[i] && short_det_r[i];
            summary[i] = |ch_err[i];
        end
    end

    // module and internal flag bytes
    always_comb begin
        mod_flags = 8'h00;
        mod_flags[apd_pkg::MF_FAIL]  = in_r[NCH];
        mod_flags[apd_pkg::MF_INT]   = in_r[NCH+1];
        mod_flags[apd_pkg::MF_EXT]   = in_r[NCH+2];
        mod_flags[apd_pkg::MF_CHAN]  = |summary;
        mod_flags[apd_pkg::MF_AUX]   = in_r[NCH+3];
        mod_flags[apd_pkg::MF_PARAM] = |par_err;
        int_flags = 8'h00;
        int_flags[apd_pkg::IF_OVF]   = in_r[NCH+4];
        int_flags[apd_pkg::IF_COMM]  = in_r[NCH+5];
        flags_all = {mod_flags, int_flags, 12'h000, summary};
    end

    // indicators follow channel errors; no interrupt exists
    assign chan_err_led = summary;

    // stamp taken whenever a module, internal or channel summary flag newly appears
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            flags_prev_r <= 32'h0000_0000;
            stamp_r      <= 32'h0000_0000;
        end else begin
            flags_prev_r <= flags_all;
            if (|(flags_all & ~flags_prev_r)) stamp_r <= us_r;
        end
    end

    // ---------------------------------------------------------------
    // record read and answer
    // ---------------------------------------------------------------
    function automatic logic [7:0] diag_byte(input logic [4:0] b);
        logic [7:0] v;
        v = 8'h00;
        unique case (b)
            apd_pkg::POS_MOD_FLAGS: v = mod_flags;
            apd_pkg::POS_CLASS:     v = apd_pkg::MODULE_CLASS;
            apd_pkg::POS_INT_FLAGS: v = int_flags;
            apd_pkg::POS_KIND:      v = apd_pkg::CHANNEL_KIND;
            apd_pkg::POS_BITS:      v = apd_pkg::BITS_PER_CH;
            apd_pkg::POS_COUNT:     v = apd_pkg::CH_COUNT;
            apd_pkg::POS_SUMMARY:   v = {4'h0, summary};
            default: begin
                if (b >= apd_pkg::POS_CH_ERR && b < apd_pkg::POS_CH_ERR + 5'(NCH))
                    v = ch_err[2'(b - apd_pkg::POS_CH_ERR)];
                else if (b >= apd_pkg::POS_STAMP)
                    v = stamp_r[8*(b - apd_pkg::POS_STAMP) +: 8];
            end
        endcase
        return v;
    endfunction

    logic rd_ok, wr_ok;
    assign rd_ok = (is_full && rec_byte < apd_pkg::DIAG_BYTES) || (is_head && rec_byte < apd_pkg::HEAD_BYTES)
                   || (is_func && rec_byte == 5'h0_0);
    assign wr_ok = !use_index && ((rec_num == apd_pkg::REC_DIAG_HEAD && rec_byte == apd_pkg::BYTE_SHORT_DET)
                   || (is_func && rec_byte == 5'h0_0));

    // one cycle answer to each strobe
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rec_rdata <= 8'h00;
            rec_ack   <= 1'b0;
            rec_err   <= 1'b0;
        end else begin
            rec_ack <= rec_rd || rec_wr;
            rec_err <= (rec_rd && !rd_ok) || (rec_wr && !wr_ok);
            if (rec_rd)
                rec_rdata <= !rd_ok ? 8'h00 : is_func ? func_r[rnum[1:0]] : diag_byte(rec_byte);
        end
    end

    // ---------------------------------------------------------------
    // output scaling per channel
    // ---------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            logic signed [15:0] d;
            logic [14:0]        lim;
            logic [28:0]        prod;
            logic               alt_sc;
            assign d    = ao_value[16*g +: 16];
            assign alt_sc = func_r[g] == apd_pkg::FN_ALT;
            // clamp below zero and above overrange top
            assign lim  = d < 0 ? 15'h0000 : alt_sc ? (16'(d) > apd_pkg::ALT_MAX ? apd_pkg::ALT_MAX[14:0] : d[14:0])
                                 : (16'(d) > apd_pkg::STD_MAX ? apd_pkg::STD_MAX[14:0] : d[14:0]);
            assign prod = lim * (alt_sc ? apd_pkg::ALT_GAIN : apd_pkg::STD_GAIN);

            // registered code and channel enable
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    dac_code[DW*g +: DW] <= '0;
                    chan_on[g]           <= 1'b0;
                end else begin
                    chan_on[g]           <= !(func_r[g] == apd_pkg::FN_OFF || par_err[g]);
                    dac_code[DW*g +: DW] <= (func_r[g] == apd_pkg::FN_OFF) ? '0 : prod[16 +: DW];
                end
            end
        end
    endgenerate

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence req_s;
        rec_rd || rec_wr;
    endsequence
    sequence answer_s;
        ##1 rec_ack;
    endsequence

    // ticker steps once per microsecond
    ticker_step_a: assert property (tick |=> us_r == $past(us_r) + 32'h0000_0001) else $error("ticker step");
    ticker_hold_a: assert property (!tick |=> us_r == $past(us_r)) else $error("ticker moved early");
    // output scaling and switch-off
    off_mode_a: assert property (func_r[2] == apd_pkg::FN_OFF |=> !chan_on[2] && dac_code[2*DW +: DW] == '0)
        else $error("channel not off");
    clamp_neg_a: assert property ($signed(ao_value[15:0]) < 0 |=> dac_code[DW-1:0] == '0)
        else $error("negative not clamped");
    overrange_a: assert property (func_r[0] == apd_pkg::FN_STD && ao_value[15:0] > apd_pkg::STD_MAX
        && !ao_value[15] |=> dac_code[DW-1:0] == DW'((32'(apd_pkg::STD_MAX) * apd_pkg::STD_GAIN) >> 16))
        else $error("overrange not limited");
    alt_range_a: assert property (func_r[1] == apd_pkg::FN_ALT && ao_value[31:16] > apd_pkg::ALT_MAX
        && !ao_value[31] |=> dac_code[2*DW-1:DW] == DW'((32'(apd_pkg::ALT_MAX) * apd_pkg::ALT_GAIN) >> 16))
        else $error("second range not limited");
    // diagnostic flags and timestamp
    short_gate_a: assert property (in_r[0] && !short_det_r[0] && !par_err[0] |-> !chan_err_led[0])
        else $error("short flagged while disabled");
    short_set_a: assert property (in_r[1] && short_det_r[1]
        |-> chan_err_led[1] && ch_err[1][apd_pkg::CE_SHORT]) else $error("enabled short not flagged");
    chan_bit_a: assert property (mod_flags[apd_pkg::MF_CHAN]
        == ((|(in_r[NCH-1:0] & short_det_r)) || (|par_err))) else $error("channel bit mismatch");
    stamp_take_a: assert property (|(flags_all & ~flags_prev_r) |=> stamp_r == $past(us_r))
        else $error("stamp not taken");
    stamp_hold_a: assert property (!(|(flags_all & ~flags_prev_r)) |=> stamp_r == $past(stamp_r))
        else $error("stamp moved without event");
    // record port answers and stores
    answer_one_a: assert property (req_s |-> answer_s ##1 (!rec_ack || $past(rec_rd || rec_wr, 1)))
        else $error("answer timing");
    head_only_a: assert property (rec_rd && is_head && !is_full && rec_byte >= apd_pkg::HEAD_BYTES
        |=> rec_err && rec_rdata == 8'h00) else $error("head record overrun");
    index_write_a: assert property (rec_wr && use_index |=> rec_ack && rec_err) else $error("index write taken");
    class_byte_a: assert property (rec_rd && is_full && rec_byte == apd_pkg::POS_CLASS
        |=> rec_rdata == apd_pkg::MODULE_CLASS) else $error("class byte wrong");
    func_store_a: assert property (rec_wr && !use_index && rec_num == apd_pkg::REC_FUNC_BASE + 8'h01
        && rec_byte == 5'h0_0 |=> func_r[1] == $past(rec_wdata)) else $error("function number not stored");
    enable_store_a: assert property (rec_wr && !use_index && rec_num == apd_pkg::REC_DIAG_HEAD
        && rec_byte == apd_pkg::BYTE_SHORT_DET |=> {4'h0, short_det_r} == ($past(rec_wdata) & 8'h0f))
        else $error("short enable not stored");
endmodule // apd_record
`default_nettype wire

// *** bench/apd_ctl_model.sv ***
// controller side model issuing single byte record accesses
`timescale 1ns/1ps
`default_nettype none
module apd_ctl_model (
    input  wire logic        clk_sys,    // system clock
    input  wire logic [7:0]  rec_rdata,  // read byte
    input  wire logic        rec_ack,    // access answered
    input  wire logic        rec_err,    // access refused
    output logic             rec_wr,     // write strobe
    output logic             rec_rd,     // read strobe
    output logic             use_index,  // index addressing
    output logic [7:0]       rec_num,    // record number
    output logic [15:0]      obj_index,  // object index
    output logic [4:0]       rec_byte,   // byte position
    output logic [7:0]       rec_wdata   // write byte
);
    // idle bus at time zero
    initial begin
        rec_wr = 1'b0;
        rec_rd = 1'b0;
        use_index = 1'b0;
        rec_num = 8'h00;
        obj_index = 16'h0000;
        rec_byte = 5'h00;
        rec_wdata = 8'h00;
    end
    // one strobe cycle, then bounded wait for the answer
    task automatic xfer(input logic wr, input logic by_idx, input logic [15:0] adr, input logic [4:0] bt,
                        input logic [7:0] wd, output logic [7:0] rd, output logic er);
        int n;
        @(negedge clk_sys);
        rec_wr = wr;
        rec_rd = !wr;
        use_index = by_idx;
        rec_num = adr[7:0];
        obj_index = adr;
        rec_byte = bt;
        rec_wdata = wd;
        @(negedge clk_sys);
        rec_wr = 1'b0;
        rec_rd = 1'b0;
        // released record number, index and write byte no longer show the old value
        rec_num = ~rec_num;
        obj_index = ~obj_index;
        rec_wdata = ~rec_wdata;
        n = 0;
        while (rec_ack !== 1'b1 && n < 4) begin
            @(negedge clk_sys);
            n++;
        end
        rd = rec_rdata;
        er = (rec_ack === 1'b1) ? rec_err : 1'bx;
    endtask
endmodule // apd_ctl_model
`default_nettype wire

// *** bench/testbench.sv ***
// self-checking bench for the parameter and diagnostic record block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk_sys, rstn, rec_wr, rec_rd, use_index, rec_ack, rec_err, er;
    logic [7:0]  rec_num, rec_wdata, rec_rdata, rd;
    logic [15:0] obj_index;
    logic [4:0]  rec_byte;
    logic [63:0] ao_value;
    logic [3:0]  short_pin, chan_on, chan_err_led;
    logic [5:0]  fault_pin;
    logic [47:0] dac_code;
    logic [31:0] st1, st2;
    int          err_count, compares, cyc;
    logic [7:0]  head_exp [20] = '{1: 8'h15, 4: 8'h73, 5: 8'h08, 6: 8'h04, default: 8'h00};
    logic [15:0] vals [7] = '{16'h0000, 16'h4000, 16'h5000, 16'h6c00, 16'h7eff, 16'h7fff, 16'hfffb};
    logic [7:0]  mf_exp [6] = '{8'h01, 8'h02, 8'h04, 8'h10, 8'h00, 8'h00};
    logic [7:0]  if_exp [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'h10};

    apd_record i_dut (.clk_sys(clk_sys), .rstn(rstn), .rec_wr(rec_wr), .rec_rd(rec_rd), .use_index(use_index),
        .rec_num(rec_num), .obj_index(obj_index), .rec_byte(rec_byte), .rec_wdata(rec_wdata),
        .rec_rdata(rec_rdata), .rec_ack(rec_ack), .rec_err(rec_err), .ao_value(ao_value),
        .short_pin(short_pin), .fault_pin(fault_pin), .dac_code(dac_code), .chan_on(chan_on),
        .chan_err_led(chan_err_led));
    apd_ctl_model i_ctl (.clk_sys(clk_sys), .rec_rdata(rec_rdata), .rec_ack(rec_ack), .rec_err(rec_err),
        .rec_wr(rec_wr), .rec_rd(rec_rd), .use_index(use_index), .rec_num(rec_num),
        .obj_index(obj_index), .rec_byte(rec_byte), .rec_wdata(rec_wdata));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic by_idx, input logic [15:0] adr, input logic [4:0] bt, input logic [7:0] exp,
                          input logic eexp);
        i_ctl.xfer(1'b0, by_idx, adr, bt, 8'h00, rd, er);
        chk(32'(rd), 32'(exp));
        chk(32'(er), 32'(eexp));
    endtask
    task automatic wr_chk(input logic by_idx, input logic [15:0] adr, input logic [4:0] bt, input logic [7:0] wd,
                          input logic eexp);
        i_ctl.xfer(1'b1, by_idx, adr, bt, wd, rd, er);
        chk(32'(er), 32'(eexp));
    endtask
    task automatic rd_stamp(output logic [31:0] s);
        for (int b = 0; b < 4; b++) begin
            i_ctl.xfer(1'b0, 1'b0, 16'h0001, 5'(16 + b), 8'h00, rd, er);
            s[8*b +: 8] = rd;
        end
    endtask
    // expected code: clamp below zero and at overrange top, then gain
    function automatic logic [11:0] exp_code(input logic [7:0] fn, input logic [15:0] d);
        logic [15:0] c;
        logic [29:0] p;
        c = d[15] ? 16'h0000 : d;
        if (fn == 8'h10 && c > 16'h7eff) c = 16'h7eff;
        if (fn == 8'h20 && c > 16'h5000) c = 16'h5000;
        p = c * ((fn == 8'h10) ? apd_pkg::STD_GAIN : apd_pkg::ALT_GAIN);
        return p[27:16];
    endfunction
    task automatic report_and_stop;
        if (err_count == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // clock, timeout and test sequence
    // ------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            report_and_stop();
        end
    end
    initial begin
        rstn = 1'b0;
        ao_value = 64'h0000_0000_0000_0000;
        short_pin = 4'h0;
        fault_pin = 6'h00;
        repeat (20) @(negedge clk_sys);
        rstn = 1'b1;
        repeat (3) @(posedge clk_sys);
        // identity bytes and reset values of the full record
        for (int b = 0; b < 20; b++) begin
            rd_chk(1'b0, 16'h0001, 5'(b), head_exp[b], 1'b0);
        end
        rd_chk(1'b1, 16'h2f01, 5'd6, 8'h04, 1'b0);
        rd_chk(1'b1, 16'h5005, 5'd4, 8'h73, 1'b0);
        rd_chk(1'b1, 16'h2f00, 5'd1, 8'h15, 1'b0);
        rd_chk(1'b1, 16'h2f00, 5'd4, 8'h00, 1'b1);
        rd_chk(1'b0, 16'h0000, 5'd3, 8'h00, 1'b0);
        rd_chk(1'b0, 16'h0000, 5'd4, 8'h00, 1'b1);
        rd_chk(1'b0, 16'h0001, 5'd20, 8'h00, 1'b1);
        rd_chk(1'b0, 16'h0080, 5'd0, 8'h10, 1'b0);
        wr_chk(1'b0, 16'h0000, 5'd0, 8'h01, 1'b1);
        wr_chk(1'b1, 16'h2f01, 5'd0, 8'h01, 1'b1);
        wr_chk(1'b0, 16'h0084, 5'd0, 8'h10, 1'b1);
        // channel 1 in second scaling, 2 off, 3 with a bad function
        wr_chk(1'b0, 16'h0081, 5'd0, 8'h20, 1'b0);
        wr_chk(1'b0, 16'h0082, 5'd0, 8'hff, 1'b0);
        wr_chk(1'b0, 16'h0083, 5'd0, 8'h33, 1'b0);
        rd_chk(1'b0, 16'h0083, 5'd0, 8'h33, 1'b0);
        foreach (vals[i]) begin
            @(negedge clk_sys);
            ao_value = {4{vals[i]}};
            repeat (3) @(negedge clk_sys);
            chk(32'(dac_code[11:0]), 32'(exp_code(8'h10, vals[i])));
            chk(32'(dac_code[23:12]), 32'(exp_code(8'h20, vals[i])));
            chk(32'(chan_on), 32'h3);
            chk(32'(dac_code[35:24]), 32'h0);
        end
        chk(32'(chan_err_led), 32'h8);
        rd_chk(1'b0, 16'h0001, 5'd11, 8'h01, 1'b0);
        rd_chk(1'b0, 16'h0001, 5'd7, 8'h08, 1'b0);
        rd_chk(1'b0, 16'h0001, 5'd0, 8'h88, 1'b0);
        rd_stamp(st1);
        chk(32'(st1 != 0), 32'h1);
        // shorts on channels 0 and 1, recognition on channel 1 only
        wr_chk(1'b0, 16'h0000, 5'd1, 8'hf2, 1'b0);
        @(negedge clk_sys);
        short_pin = 4'h3;
        repeat (6) @(negedge clk_sys);
        chk(32'(chan_err_led), 32'ha);
        rd_chk(1'b0, 16'h0001, 5'd8, 8'h00, 1'b0);
        rd_chk(1'b0, 16'h0001, 5'd9, 8'h08, 1'b0);
        rd_chk(1'b0, 16'h0001, 5'd7, 8'h0a, 1'b0);
        rd_stamp(st2);
        chk(32'(st2 > st1), 32'h1);
        // module and internal fault flags one at a time
        short_pin = 4'h0;
        wr_chk(1'b0, 16'h0083, 5'd0, 8'h10, 1'b0);
        for (int i = 0; i < 6; i++) begin
            @(negedge clk_sys);
            fault_pin = 6'(1 << i);
            repeat (6) @(negedge clk_sys);
            rd_chk(1'b0, 16'h0001, 5'd0, mf_exp[i], 1'b0);
            rd_chk(1'b0, 16'h0001, 5'd3, if_exp[i], 1'b0);
        end
        report_and_stop();
    end
endmodule // testbench
`default_nettype wire
